// File: verilog/peig_gen.sv
// endpoint interrupt generator: legacy line A messages and msi writes
`timescale 1ns/1ns
`include "peig_consts.svh"
module peig_gen
   import peig_pkg::*;
#(
   parameter logic [2:0] MMC = `PEIG_DEF_MMC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata_q,
   input wire logic usr_int_req,
   input wire logic usr_msi_req,
   input wire logic [4:0] usr_msi_vector,
   output logic usr_msi_done_q,
   input wire logic usr_data_wr_pending,
   output logic pkt_valid_q,
   input wire logic pkt_ready,
   output logic [2:0] pkt_fmt_q,
   output logic [4:0] pkt_type_q,
   output logic [7:0] pkt_msg_code_q,
   output logic [9:0] pkt_length_q,
   output logic [3:0] pkt_first_be_q,
   output logic [3:0] pkt_last_be_q,
   output logic [1:0] pkt_attr_q,
   output logic [31:0] pkt_addr_q,
   output logic [31:0] pkt_data_q,
   output logic int_pending_q,
   output logic irq_q
);
   logic msi_en_q;
   logic [2:0] mme_q;
   logic [31:0] msg_addr_q;
   logic [15:0] msg_data_q;
   logic mem_pending_q;
   logic [2:0] irq_stat_q;
   logic [2:0] irq_mask_q;
   logic [2:0] irq_evt;
   logic [31:0] rd_d;
   peig_state_t st_q;
   peig_kind_t kind_q;
   logic leg_asserted_q;
   logic pkt_take;
   logic msi_start;
   logic leg_start;
   logic deassert_start;

   // merge vector bits into programmed data under the enabled width
   function automatic logic [15:0] vec_data(input logic [15:0] base,
                                            input logic [2:0] mme,
                                            input logic [4:0] vec);
      logic [15:0] m;
      m = 16'h0000;
      m[4:0] = 5'(({5'h00, 1'b1} << mme) - 6'h01);
      vec_data = (base & ~m) | ({11'h000, vec} & m);
   endfunction : vec_data

   // clamp guards software that ignores the capable value
   function automatic logic [2:0] clamp_mme(input logic [2:0] v);
      clamp_mme = (v > MMC) ? MMC : v;
   endfunction : clamp_mme

   // one write decode shared by every register except irq status, which decodes its own write
   function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] a);
      wr_hit = wr && (addr == a);
   endfunction : wr_hit

   assign pkt_take = pkt_valid_q & pkt_ready;
   // stall msi behind posted data so the msi write never overtakes it; legacy messages are not stalled
   assign msi_start = (st_q == PEIG_ST_IDLE) & msi_en_q & usr_msi_req
                      & ~usr_data_wr_pending;
   assign leg_start = (st_q == PEIG_ST_IDLE) & ~msi_en_q & usr_int_req
                      & ~leg_asserted_q;
   assign deassert_start = (st_q == PEIG_ST_ASSERTED) & ~usr_int_req;

   // register writes, one register per process
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         msi_en_q <= 1'b0;
         mme_q <= 3'h0;
      end else if (wr_hit(reg_wr, reg_addr, `PEIG_REG_CTRL)) begin
         msi_en_q <= reg_wdata[`PEIG_CTRL_MSI_EN_BIT];
         mme_q <= clamp_mme(reg_wdata[`PEIG_CTRL_MME_LSB +: 3]);
      end
   end

   // low address bits forced to zero for dword alignment
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         msg_addr_q <= 32'h0000_0000;
      end else if (wr_hit(reg_wr, reg_addr, `PEIG_REG_ADDR)) begin
         msg_addr_q <= {reg_wdata[31:2], 2'h0};
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         msg_data_q <= 16'h0000;
      end else if (wr_hit(reg_wr, reg_addr, `PEIG_REG_DATA)) begin
         msg_data_q <= reg_wdata[15:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_mask_q <= 3'h0;
      end else if (wr_hit(reg_wr, reg_addr, `PEIG_REG_IRQ_MASK)) begin
         irq_mask_q <= reg_wdata[2:0];
      end
   end

   // events: assert sent, deassert sent, msi sent
   assign irq_evt = {pkt_take & (kind_q == PEIG_KIND_MSI),
                     pkt_take & (kind_q == PEIG_KIND_DEASSERT),
                     pkt_take & (kind_q == PEIG_KIND_ASSERT)};

   // set wins over write-one-to-clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_stat_q <= 3'h0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~((reg_wr && reg_addr == `PEIG_REG_IRQ_STAT) ?
                        reg_wdata[2:0] : 3'h0)) | irq_evt;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   // read mux
   always_comb begin
      rd_d = 32'h0000_0000;
      unique case (reg_addr)
         `PEIG_REG_CTRL: begin
            rd_d[`PEIG_CTRL_MSI_EN_BIT] = msi_en_q;
            rd_d[`PEIG_CTRL_MME_LSB +: 3] = mme_q;
            rd_d[`PEIG_CTRL_MMC_LSB +: 3] = MMC;
         end
         `PEIG_REG_ADDR: rd_d = msg_addr_q;
         `PEIG_REG_DATA: rd_d = {16'h0000, msg_data_q};
         `PEIG_REG_STAT: rd_d = {28'h0, leg_asserted_q, st_q != PEIG_ST_IDLE,
                                 mem_pending_q, int_pending_q};
         `PEIG_REG_IRQ_STAT: rd_d = {29'h0, irq_stat_q};
         `PEIG_REG_IRQ_MASK: rd_d = {29'h0, irq_mask_q};
         default: rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_q <= 32'h0000_0000;
      end else begin
         reg_rdata_q <= reg_rd ? rd_d : 32'h0000_0000;
      end
   end

   // message sequencer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= PEIG_ST_IDLE;
         kind_q <= PEIG_KIND_NONE;
         leg_asserted_q <= 1'b0;
      end else begin
         unique case (st_q)
            PEIG_ST_IDLE: begin
               if (msi_start) begin
                  st_q <= PEIG_ST_SEND;
                  kind_q <= PEIG_KIND_MSI;
               end else if (leg_start) begin
                  st_q <= PEIG_ST_SEND;
                  kind_q <= PEIG_KIND_ASSERT;
               end
            end
            PEIG_ST_SEND: begin
               if (pkt_take) begin
                  if (kind_q == PEIG_KIND_ASSERT) begin
                     st_q <= PEIG_ST_ASSERTED;
                     leg_asserted_q <= 1'b1;
                  end else begin
                     st_q <= PEIG_ST_IDLE;
                     leg_asserted_q <= 1'b0;
                  end
                  kind_q <= PEIG_KIND_NONE;
               end
            end
            PEIG_ST_ASSERTED: begin
               // deassert is still owed after msi gets enabled
               if (deassert_start) begin
                  st_q <= PEIG_ST_SEND;
                  kind_q <= PEIG_KIND_DEASSERT;
               end
            end
            default: st_q <= PEIG_ST_IDLE;
         endcase
      end
   end

   // offer raised on any start, dropped once taken; fields hold meanwhile
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pkt_valid_q <= 1'b0;
      end else if (msi_start || leg_start || deassert_start) begin
         pkt_valid_q <= 1'b1;
      end else if (pkt_take) begin
         pkt_valid_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pkt_fmt_q <= 3'h0;
      end else if (msi_start) begin
         pkt_fmt_q <= `PEIG_FMT_MWR32;
      end else if (leg_start || deassert_start) begin
         pkt_fmt_q <= `PEIG_FMT_MSG;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pkt_type_q <= 5'h00;
      end else if (msi_start) begin
         pkt_type_q <= `PEIG_TYPE_MWR;
      end else if (leg_start || deassert_start) begin
         pkt_type_q <= `PEIG_TYPE_MSG_LOCAL;
      end
   end

   // only line a codes exist here
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pkt_msg_code_q <= 8'h00;
      end else if (msi_start) begin
         pkt_msg_code_q <= 8'h00;
      end else if (leg_start || deassert_start) begin
         pkt_msg_code_q <= leg_start ? `PEIG_CODE_ASSERT_A : `PEIG_CODE_DEASSERT_A;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pkt_length_q <= 10'h000;
      end else if (msi_start) begin
         pkt_length_q <= `PEIG_LEN_ONE_DW;
      end else if (leg_start || deassert_start) begin
         pkt_length_q <= 10'h000;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pkt_first_be_q <= 4'h0;
      end else if (msi_start) begin
         pkt_first_be_q <= `PEIG_FIRST_BE_ALL;
      end else if (leg_start || deassert_start) begin
         pkt_first_be_q <= 4'h0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pkt_last_be_q <= 4'h0;
      end else if (msi_start) begin
         pkt_last_be_q <= `PEIG_LAST_BE_NONE;
      end else if (leg_start || deassert_start) begin
         pkt_last_be_q <= 4'h0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pkt_attr_q <= 2'h0;
      end else if (msi_start) begin
         pkt_attr_q <= `PEIG_ATTR_NONE;
      end else if (leg_start || deassert_start) begin
         pkt_attr_q <= `PEIG_ATTR_NONE;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pkt_addr_q <= 32'h0000_0000;
      end else if (msi_start) begin
         pkt_addr_q <= msg_addr_q;
      end else if (leg_start || deassert_start) begin
         pkt_addr_q <= 32'h0000_0000;
      end
   end

   // vector sampled at start so a changing request cannot tear the payload
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pkt_data_q <= 32'h0000_0000;
      end else if (msi_start) begin
         pkt_data_q <= {16'h0000, vec_data(msg_data_q, mme_q, usr_msi_vector)};
      end else if (leg_start || deassert_start) begin
         pkt_data_q <= 32'h0000_0000;
      end
   end

   // pending indications follow the line
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         int_pending_q <= 1'b0;
      end else if (pkt_take && kind_q == PEIG_KIND_ASSERT) begin
         int_pending_q <= 1'b1;
      end else if (pkt_take && kind_q == PEIG_KIND_DEASSERT) begin
         int_pending_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_pending_q <= 1'b0;
      end else if (pkt_take && kind_q == PEIG_KIND_ASSERT) begin
         mem_pending_q <= 1'b1;
      end else if (pkt_take && kind_q == PEIG_KIND_DEASSERT) begin
         mem_pending_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         usr_msi_done_q <= 1'b0;
      end else begin
         usr_msi_done_q <= pkt_take & (kind_q == PEIG_KIND_MSI);
      end
   end
endmodule : peig_gen

// File: verilog/peig_consts.svh
// constants for the endpoint interrupt generator
`ifndef PEIG_CONSTS_SVH
`define PEIG_CONSTS_SVH
`define PEIG_REG_CTRL 8'h00
`define PEIG_REG_ADDR 8'h04
`define PEIG_REG_DATA 8'h08
`define PEIG_REG_STAT 8'h0c
`define PEIG_REG_IRQ_STAT 8'h10
`define PEIG_REG_IRQ_MASK 8'h14
`define PEIG_CTRL_MSI_EN_BIT 0
`define PEIG_CTRL_MME_LSB 4
`define PEIG_CTRL_MMC_LSB 8
`define PEIG_DEF_MMC 3'h5
`define PEIG_FMT_MWR32 3'h2
`define PEIG_TYPE_MWR 5'h00
`define PEIG_FMT_MSG 3'h1
`define PEIG_TYPE_MSG_LOCAL 5'h14
`define PEIG_CODE_ASSERT_A 8'h20
`define PEIG_CODE_DEASSERT_A 8'h24
`define PEIG_LEN_ONE_DW 10'h001
`define PEIG_FIRST_BE_ALL 4'hf
`define PEIG_LAST_BE_NONE 4'h0
`define PEIG_ATTR_NONE 2'h0
`endif

// File: verilog/peig_pkg.sv
// types for the endpoint interrupt generator
package peig_pkg;
   typedef enum logic [1:0] {
      PEIG_KIND_NONE = 2'h0,
      PEIG_KIND_ASSERT = 2'h1,
      PEIG_KIND_DEASSERT = 2'h2,
      PEIG_KIND_MSI = 2'h3
   } peig_kind_t;
   typedef enum logic [1:0] {
      PEIG_ST_IDLE = 2'h0,
      PEIG_ST_SEND = 2'h1,
      PEIG_ST_ASSERTED = 2'h2
   } peig_state_t;
endpackage : peig_pkg

// File: verif/peig_props.sv
// port assertions for the interrupt generator
`timescale 1ns/1ns
`include "peig_consts.svh"
module peig_props (
   input logic clk,
   input logic arst_n,
   input logic usr_data_wr_pending,
   input logic usr_msi_done_q,
   input logic pkt_valid_q,
   input logic pkt_ready,
   input logic [2:0] pkt_fmt_q,
   input logic [7:0] pkt_msg_code_q,
   input logic [9:0] pkt_length_q,
   input logic [3:0] pkt_first_be_q,
   input logic [3:0] pkt_last_be_q,
   input logic [1:0] pkt_attr_q,
   input logic [31:0] pkt_data_q,
   input logic int_pending_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic acc, msi, msg;
   assign acc = pkt_valid_q && pkt_ready;
   assign msi = pkt_fmt_q == `PEIG_FMT_MWR32;
   assign msg = pkt_fmt_q == `PEIG_FMT_MSG;
   msi_shape_a: assert property (pkt_valid_q && msi |-> pkt_length_q == `PEIG_LEN_ONE_DW
      && pkt_first_be_q == `PEIG_FIRST_BE_ALL && pkt_last_be_q == `PEIG_LAST_BE_NONE)
      else $error("msi shape wrong");
   attr_clear_a: assert property (pkt_valid_q && msi |-> pkt_attr_q == `PEIG_ATTR_NONE)
      else $error("msi attr set");
   line_a_a: assert property (pkt_valid_q && msg |->
      pkt_msg_code_q inside {`PEIG_CODE_ASSERT_A, `PEIG_CODE_DEASSERT_A}) else $error("bad line");
   data_hold_a: assert property (pkt_valid_q && !pkt_ready |=>
      pkt_valid_q && $stable(pkt_data_q)) else $error("offer dropped");
   drop_a: assert property (acc |=> !pkt_valid_q) else $error("offer kept");
   pend_set_a: assert property (acc && msg && pkt_msg_code_q == `PEIG_CODE_ASSERT_A
      |=> int_pending_q) else $error("pending not set");
   pend_clr_a: assert property (acc && msg && pkt_msg_code_q == `PEIG_CODE_DEASSERT_A
      |=> !int_pending_q) else $error("pending not cleared");
   wr_order_a: assert property ($rose(pkt_valid_q) && msi |->
      !$past(usr_data_wr_pending)) else $error("msi passed data");
   msi_done_a: assert property (acc && msi |=> usr_msi_done_q ##1 !usr_msi_done_q)
      else $error("done pulse wrong");
   cover property (acc && msi);
   cover property (acc && msg);
   cover property (pkt_valid_q && !pkt_ready);
endmodule : peig_props

// File: verif/peig_rc_model.sv
// root complex model: accepts packets after a set stall
`timescale 1ns/1ns
module peig_rc_model (
   input logic clk,
   input logic arst_n,
   input logic pkt_valid_q,
   input logic [3:0] delay,
   output logic pkt_ready
);
   logic [3:0] wait_q;
   // stall lets the bench prove fields hold under back pressure
   assign pkt_ready = pkt_valid_q && (wait_q >= delay);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_q <= 4'h0;
      end else if (pkt_valid_q && !pkt_ready) begin
         wait_q <= wait_q + 4'h1;
      end else begin
         wait_q <= 4'h0;
      end
   end
endmodule : peig_rc_model

// File: verif/test_pcie_endpoint_interrupt_gen.sv
// bench for the endpoint interrupt generator
`timescale 1ns/1ns
`include "peig_consts.svh"
module test_pcie_endpoint_interrupt_gen;
   logic clk, pkt_valid_q, pkt_ready, usr_msi_done_q, int_pending_q, irq_q;
   logic arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, usr_int_req = 1'b0, usr_msi_req = 1'b0;
   logic usr_data_wr_pending = 1'b0;
   logic [7:0] reg_addr = 8'h00, pkt_msg_code_q, cap_code;
   logic [31:0] reg_wdata = 32'h0, reg_rdata_q, pkt_addr_q, pkt_data_q, cap_addr, cap_data, rv;
   logic [4:0] usr_msi_vector = 5'h00, pkt_type_q;
   logic [3:0] delay = 4'h3, pkt_first_be_q, pkt_last_be_q;
   logic [2:0] pkt_fmt_q;
   logic [9:0] pkt_length_q;
   logic [1:0] pkt_attr_q;
   logic [27:0] cap_hdr;
   int n_pkt = 0, n_mismatch = 0, n_compared = 0, cyc = 0;
   peig_gen #(.MMC(3'h3)) uut (.*);
   peig_rc_model rc (.*);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (pkt_valid_q && pkt_ready) begin
         cap_hdr <= {pkt_fmt_q, pkt_type_q, pkt_length_q, pkt_first_be_q, pkt_last_be_q, pkt_attr_q};
         cap_code <= pkt_msg_code_q;
         cap_addr <= pkt_addr_q;
         cap_data <= pkt_data_q;
         n_pkt <= n_pkt + 1;
      end
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         summarize;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata_q;
   endtask : rd
   // bounded wait until the model has taken n packets
   task automatic wait_pkt(input int n);
      for (int i = 0; i < 60 && n_pkt < n; i++) begin
         @(posedge clk);
         #1;
      end
   endtask : wait_pkt
   task automatic t_regs;
      rd(`PEIG_REG_CTRL);
      chk(rv, 32'h0000_0300);
      rd(8'h20);
      chk(rv, 32'h0);
      wr(`PEIG_REG_CTRL, 32'h70);
      rd(`PEIG_REG_CTRL);
      chk(rv, 32'h0000_0330);
   endtask : t_regs
   task automatic t_legacy;
      @(posedge clk);
      usr_int_req <= 1'b1;
      wait_pkt(1);
      chk(cap_hdr[27:20], {`PEIG_FMT_MSG, `PEIG_TYPE_MSG_LOCAL});
      chk(cap_code, `PEIG_CODE_ASSERT_A);
      chk(int_pending_q, 1'b1);
      rd(`PEIG_REG_STAT);
      chk(rv[1:0], 2'h3);
      @(posedge clk);
      usr_int_req <= 1'b0;
      wait_pkt(2);
      chk(cap_code, `PEIG_CODE_DEASSERT_A);
      chk(int_pending_q, 1'b0);
      rd(`PEIG_REG_STAT);
      chk(rv[1:0], 2'h0);
      repeat (6) @(posedge clk);
      chk(n_pkt, 2);
   endtask : t_legacy
   task automatic t_msi;
      wr(`PEIG_REG_ADDR, 32'h8000_1000);
      wr(`PEIG_REG_DATA, 32'h0000_abcd);
      wr(`PEIG_REG_CTRL, 32'h31);
      delay <= 4'h0;
      usr_data_wr_pending <= 1'b1;
      usr_msi_vector <= 5'h1e;
      usr_msi_req <= 1'b1;
      repeat (8) @(posedge clk);
      chk(n_pkt, 2);
      usr_data_wr_pending <= 1'b0;
      @(posedge clk);
      usr_msi_req <= 1'b0;
      wait_pkt(3);
      chk(cap_hdr, {`PEIG_FMT_MWR32, `PEIG_TYPE_MWR, 20'h007c0});
      chk(cap_addr, 32'h8000_1000);
      chk(cap_data, 32'h0000_abce);
      chk(usr_msi_done_q, 1'b1);
      @(posedge clk);
      usr_int_req <= 1'b1;
      repeat (10) @(posedge clk);
      chk(n_pkt, 3);
      chk(irq_q, 1'b0);
      usr_int_req <= 1'b0;
      wr(`PEIG_REG_IRQ_MASK, 32'h4);
      rd(`PEIG_REG_IRQ_STAT);
      chk(rv[2:0], 3'h7);
      chk(irq_q, 1'b1);
      wr(`PEIG_REG_IRQ_STAT, 32'h7);
      repeat (2) @(posedge clk);
      #1 chk(irq_q, 1'b0);
   endtask : t_msi
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      t_regs;
      t_legacy;
      t_msi;
      summarize;
   end
endmodule : test_pcie_endpoint_interrupt_gen
bind peig_gen peig_props props_i (.*);
